// File: ssfd_pkg.sv
// Constants shared by the full-duplex synchronous serial port
package ssfd_pkg;
	localparam logic [1:0] SSFD_MODE_FULL_DUPLEX = 2'h2;   // Operating mode code for transmit/receive
	localparam int         SSFD_BITS            = 8;      // Bits per byte
	localparam logic [3:0] SSFD_LAST_BIT        = 4'h8;   // Count at the eighth edge
	localparam logic [7:0] SSFD_BYTE_RESET      = 8'h00;  // Buffer reset value
	localparam int         SSFD_SYS_CLK_NS      = 10;     // System clock period in ns
	localparam int         SSFD_SCK_PERIOD_NS   = 800;    // Internal serial clock period in ns
	localparam int         SSFD_SCK_HALF_CYC    = SSFD_SCK_PERIOD_NS / (2 * SSFD_SYS_CLK_NS);
endpackage : ssfd_pkg

// File: ssfd_port.sv
// Full-duplex synchronous serial port, device side
`timescale 1ns/1ps
`default_nettype none
module ssfd_port
	import ssfd_pkg::*;
#(
	parameter int SCK_HALF_CYC = SSFD_SCK_HALF_CYC   // System cycles per half serial clock
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       ctrl_wr,
	input  wire logic [1:0] ctrl_mode,
	input  wire logic       ctrl_dir_lsb,
	input  wire logic       ctrl_ext_clk,
	input  wire logic       ctrl_start,
	input  wire logic       ctrl_inhibit,
	input  wire logic       tx_wr,
	input  wire logic [7:0] tx_wdata,
	input  wire logic       rx_rd,
	input  wire logic       rx_err_clr,
	output logic [7:0]      rx_rdata,
	output logic            transfer_start_bit,
	output logic            operating_flag,
	output logic            shift_active_flag,
	output logic            tx_buffer_empty_flag,
	output logic            rx_buffer_full_flag,
	output logic            tx_underrun_flag,
	output logic            rx_overrun_flag,
	output logic            port_irq,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe,
	output logic            so_out,
	input  wire logic       si_in
);
	generate
		if (SCK_HALF_CYC < 2) begin : g_bad_half
			$error("SCK_HALF_CYC must be at least 2");
		end
	endgenerate

	localparam int DW = $clog2(SCK_HALF_CYC + 1);

	logic [1:0]    operating_mode_field;   // Stored mode field
	logic          bit_order_select;       // 1: lsb first
	logic          ext_clk;                // 1: clock from pin
	logic          forced_stop_bit;        // Inhibit held
	logic [7:0]    tx_buffer;              // Software transmit byte
	logic [7:0]    rx_buffer;              // Last good received byte
	logic [7:0]    shreg;                  // Shared shift register
	logic          in_byte;                // Byte in progress
	logic [3:0]    fall_cnt;               // Falling edges this byte
	logic [3:0]    rise_cnt;               // Rising edges this byte
	logic          tx_load_pend;           // Empty flag due at next rise
	logic          read_once;              // Recovery read already made
	logic          sck_s1, sck_s2, sck_s3; // External clock synchroniser
	logic          si_s1, si_s2;           // Data-in synchroniser
	logic [DW-1:0] div;                    // Internal clock divider
	logic          run_ok;                 // Mode valid and not inhibited
	logic          int_go;                 // Internal clock may start a byte
	logic          int_run;                // Internal divider running
	logic          tick;                   // Half period elapsed
	logic          fall_ev;                // Serial clock falling edge
	logic          rise_ev;                // Serial clock rising edge
	logic          byte_done;              // Eighth rising edge
	logic          inhibit_now;            // Inhibit written this cycle
	logic          byte_go;                // A byte may start at the next fall

	// Only mode 10 runs the port; other modes stay idle
	assign run_ok      = (operating_mode_field == SSFD_MODE_FULL_DUPLEX) && !forced_stop_bit;
	assign inhibit_now = ctrl_wr && ctrl_inhibit;
	// After an overrun with start cleared, one more external byte runs to its end
	assign byte_go     = transfer_start_bit || (ext_clk && rx_overrun_flag && operating_flag);
	// Auto-wait: a new byte needs a fresh tx write and the rx buffer read
	assign int_go  = transfer_start_bit && !tx_buffer_empty_flag && !rx_buffer_full_flag;
	assign int_run = run_ok && !ext_clk && (in_byte || int_go);
	assign tick    = (div == DW'(SCK_HALF_CYC - 1));

	// Edge events from either source, one cycle each
	always_comb begin
		if (ext_clk) begin
			fall_ev = run_ok && sck_s3 && !sck_s2;
			rise_ev = run_ok && !sck_s3 && sck_s2;
		end else begin
			fall_ev = int_run && tick && sck_out;
			rise_ev = int_run && tick && !sck_out;
		end
	end
	assign byte_done = rise_ev && in_byte && (rise_cnt == SSFD_LAST_BIT - 4'h1);

	// Pin synchronisers; data reads the second stage, clock edges compare the second and third
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_s3 <= 1'b1;
			si_s1  <= 1'b1;
			si_s2  <= 1'b1;
		end else begin
			sck_s1 <= sck_in;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			si_s1  <= si_in;
			si_s2  <= si_s1;
		end
	end

	// Control register; inhibit clears start at once
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			operating_mode_field <= 2'h0;
			bit_order_select     <= 1'b0;
			ext_clk              <= 1'b0;
			transfer_start_bit   <= 1'b0;
			forced_stop_bit      <= 1'b0;
		end else if (ctrl_wr) begin
			operating_mode_field <= ctrl_mode;
			bit_order_select     <= ctrl_dir_lsb;
			ext_clk              <= ctrl_ext_clk;
			forced_stop_bit      <= ctrl_inhibit;
			transfer_start_bit   <= ctrl_start && !ctrl_inhibit;
		end
	end

	// Internal clock divider; idles high so a wait holds the line high
	always_ff @(posedge sys_clk) begin
		if (rst || inhibit_now) begin
			div     <= '0;
			sck_out <= 1'b1;
		end else if (int_run) begin
			div <= tick ? '0 : div + DW'(1);
			if (tick) begin
				sck_out <= !sck_out;
			end
		end else begin
			div     <= '0;
			sck_out <= 1'b1;
		end
	end

	// Clock pin is driven only for internal clocking
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sck_oe <= 1'b0;
		end else begin
			sck_oe <= run_ok && !ext_clk;
		end
	end

	// Byte sequencing, shift register and data-out pin
	always_ff @(posedge sys_clk) begin
		if (rst || inhibit_now) begin
			in_byte           <= 1'b0;
			fall_cnt          <= 4'h0;
			rise_cnt          <= 4'h0;
			shift_active_flag <= 1'b0;
			operating_flag    <= 1'b0;
			shreg             <= SSFD_BYTE_RESET;
			so_out            <= 1'b1;
		end else begin
			// Start cleared with no byte running and no overrun byte due: stop at once, line high
			if (!in_byte && !byte_go) begin
				operating_flag <= 1'b0;
				so_out         <= 1'b1;
			end
			if (fall_ev && !in_byte && byte_go) begin
				// First fall: load buffer and put out first bit
				in_byte           <= 1'b1;
				fall_cnt          <= 4'h1;
				rise_cnt          <= 4'h0;
				shift_active_flag <= 1'b1;
				operating_flag    <= 1'b1;
				if (!rx_overrun_flag) begin
					shreg <= tx_buffer;
				end
				if (tx_buffer_empty_flag) begin
					so_out <= 1'b1;
				end else begin
					so_out <= bit_order_select ? tx_buffer[0] : tx_buffer[SSFD_BITS-1];
				end
			end else if (fall_ev && in_byte) begin
				fall_cnt <= fall_cnt + 4'h1;
				if (fall_cnt == SSFD_LAST_BIT - 4'h1) begin
					shift_active_flag <= 1'b0;
				end
				// Underrun keeps the line high for the whole byte
				if (tx_underrun_flag) begin
					so_out <= 1'b1;
				end else begin
					so_out <= bit_order_select ? shreg[0] : shreg[SSFD_BITS-1];
				end
			end
			if (rise_ev && in_byte) begin
				rise_cnt <= rise_cnt + 4'h1;
				// Overrun freezes the shift register for recovery
				if (!rx_overrun_flag) begin
					if (bit_order_select) begin
						shreg <= {si_s2, shreg[SSFD_BITS-1:1]};
					end else begin
						shreg <= {shreg[SSFD_BITS-2:0], si_s2};
					end
				end
				if (byte_done) begin
					in_byte <= 1'b0;
					// Start cleared: finish here and idle the line high
					if (!transfer_start_bit) begin
						operating_flag <= 1'b0;
						so_out         <= 1'b1;
					end
				end
			end
		end
	end

	// Transmit buffer and empty flag; hardware set beats a write
	always_ff @(posedge sys_clk) begin
		if (rst || inhibit_now) begin
			tx_buffer            <= SSFD_BYTE_RESET;
			tx_buffer_empty_flag <= 1'b1;
			tx_load_pend         <= 1'b0;
		end else begin
			if (tx_wr) begin
				tx_buffer <= tx_wdata;
			end
			if (fall_ev && !in_byte && byte_go && !tx_buffer_empty_flag) begin
				tx_load_pend <= 1'b1;
			end else if (rise_ev && tx_load_pend) begin
				tx_load_pend <= 1'b0;
			end
			if (rise_ev && tx_load_pend) begin
				tx_buffer_empty_flag <= 1'b1;
			end else if (tx_wr) begin
				tx_buffer_empty_flag <= 1'b0;
			end
		end
	end

	// Underrun: byte began with nothing written
	always_ff @(posedge sys_clk) begin
		if (rst || inhibit_now) begin
			tx_underrun_flag <= 1'b0;
		end else if (fall_ev && !in_byte && byte_go && tx_buffer_empty_flag) begin
			tx_underrun_flag <= 1'b1;
		end
	end

	// Receive buffer, full flag, overrun and interrupt
	always_ff @(posedge sys_clk) begin
		if (rst || inhibit_now) begin
			rx_buffer           <= SSFD_BYTE_RESET;
			rx_buffer_full_flag <= 1'b0;
			rx_overrun_flag     <= 1'b0;
			port_irq            <= 1'b0;
			read_once           <= 1'b0;
		end else begin
			port_irq <= 1'b0;
			if (byte_done && !rx_overrun_flag && rx_buffer_full_flag) begin
				// Unread byte: keep it and the shift register
				rx_overrun_flag <= 1'b1;
			end else if (byte_done && !rx_overrun_flag) begin
				rx_buffer           <= bit_order_select ? {si_s2, shreg[SSFD_BITS-1:1]}
				                                        : {shreg[SSFD_BITS-2:0], si_s2};
				rx_buffer_full_flag <= 1'b1;
				port_irq            <= 1'b1;
			end else if (rx_err_clr) begin
				rx_overrun_flag     <= 1'b0;
				rx_buffer_full_flag <= 1'b0;
				read_once           <= 1'b0;
			end else if (rx_rd) begin
				// In overrun the full flag stays until the error clears
				if (!rx_overrun_flag) begin
					rx_buffer_full_flag <= 1'b0;
				end
				if (rx_overrun_flag && !transfer_start_bit) begin
					read_once <= 1'b1;
				end
			end
		end
	end

	// Read data view: second recovery read shows the shift register
	always_ff @(posedge sys_clk) begin
		if (rst || inhibit_now) begin
			rx_rdata <= SSFD_BYTE_RESET;
		end else begin
			rx_rdata <= read_once ? shreg : rx_buffer;
		end
	end

	// Shift-active spans exactly eight falls
	a_active_span: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(shift_active_flag) |-> (fall_cnt == 4'h1))
		else $error("shift active rose off the first fall");
	a_active_drop: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(shift_active_flag) && !$past(inhibit_now) |-> (fall_cnt == SSFD_LAST_BIT))
		else $error("shift active fell off the eighth fall");
	a_txwr_clears: assert property (@(posedge sys_clk) disable iff (rst)
		tx_wr && !inhibit_now && !(rise_ev && tx_load_pend) |=> !tx_buffer_empty_flag)
		else $error("write did not clear empty flag");
	a_rd_clears: assert property (@(posedge sys_clk) disable iff (rst)
		rx_rd && !byte_done && !rx_overrun_flag && !inhibit_now |=> !rx_buffer_full_flag)
		else $error("read did not clear full flag");
	a_irq_with_full: assert property (@(posedge sys_clk) disable iff (rst)
		port_irq |-> rx_buffer_full_flag && !rx_overrun_flag && !in_byte)
		else $error("interrupt without full flag");
	a_underrun_high: assert property (@(posedge sys_clk) disable iff (rst)
		tx_underrun_flag && $past(tx_underrun_flag) |-> so_out)
		else $error("data out low during underrun");
	a_overrun_hold: assert property (@(posedge sys_clk) disable iff (rst)
		rx_overrun_flag && $past(rx_overrun_flag) && !$past(inhibit_now) |-> $stable(rx_buffer))
		else $error("receive buffer changed in overrun");
	a_inhibit_clear: assert property (@(posedge sys_clk) disable iff (rst)
		inhibit_now |=> !transfer_start_bit && !operating_flag && tx_buffer_empty_flag
			&& !rx_buffer_full_flag && !in_byte)
		else $error("inhibit did not clear state");
	a_wait_high: assert property (@(posedge sys_clk) disable iff (rst)
		!ext_clk && !in_byte && !int_go |=> sck_out)
		else $error("internal clock not parked high");
	a_stop_high: assert property (@(posedge sys_clk) disable iff (rst)
		byte_done && !transfer_start_bit && !inhibit_now |=> !operating_flag && so_out)
		else $error("stop did not idle the port");
endmodule // ssfd_port
`default_nettype wire

// File: ssfd_peer.sv
// Behavioural serial peer facing the port's clock and data pins
`timescale 1ns/1ps
`default_nettype none
module ssfd_peer (
	input  wire logic       ext,     // 1: peer makes the clock
	input  wire logic       lsb,     // Bit order, 1 lsb first
	input  wire logic       sck_out, // Port clock when internal
	input  wire logic       so_out,  // Port data out
	input  wire logic [7:0] tx_byte, // Byte the peer sends
	output logic            sck_in,  // Peer clock, parked high
	output logic            si_in,   // Peer data to port
	output logic [7:0]      rx_byte  // Byte caught from port
);
	logic [2:0] n;                                  // Bit index inside a frame
	wire logic  sck = ext ? sck_in : sck_out;       // Whichever side owns the clock
	initial begin
		sck_in = 1'b1;
		si_in  = 1'b1;
		n      = 3'h0;
	end
	// Next bit goes out on each fall
	always @(negedge sck)
		si_in <= tx_byte[lsb ? n : 3'h7 - n];
	// Port bit caught on each rise
	always @(posedge sck) begin
		rx_byte[lsb ? n : 3'h7 - n] <= so_out;
		n <= n + 3'h1;
	end
	// Power-up edges on the clock would skew the index
	task clear;
		n = 3'h0;
	endtask
	// Eight clocks, then the released line flips so stale data never looks valid
	task frame;
		repeat (8) begin
			#62.5 sck_in = 1'b0;
			#62.5 sck_in = 1'b1;
		end
		#62.5 si_in = ~si_in;
	endtask
endmodule // ssfd_peer
`default_nettype wire

// File: sync_serial_full_duplex_tb.sv
// Self-checking bench for the full-duplex serial port
`timescale 1ns/1ps
`default_nettype none
module sync_serial_full_duplex_tb;
	import ssfd_pkg::*;
	localparam int HALF = 4; // Short serial half period keeps runs brief
	logic       sys_clk, rst, ctrl_wr, ctrl_dir_lsb, ctrl_ext_clk, ctrl_start, ctrl_inhibit;
	logic       tx_wr, rx_rd, rx_err_clr, transfer_start_bit, operating_flag, shift_active_flag;
	logic       tx_buffer_empty_flag, rx_buffer_full_flag, tx_underrun_flag, rx_overrun_flag;
	logic       port_irq, sck_in, sck_out, sck_oe, so_out, si_in;
	logic [1:0] ctrl_mode;
	logic [7:0] tx_wdata, rx_rdata, peer_tx, peer_rx, b0, b1;
	int         miscompares, check_count, irqs, cycles, seed, i, k0;
	ssfd_port #(.SCK_HALF_CYC(HALF)) dut (.sys_clk, .rst, .ctrl_wr, .ctrl_mode, .ctrl_dir_lsb,
		.ctrl_ext_clk, .ctrl_start, .ctrl_inhibit, .tx_wr, .tx_wdata, .rx_rd, .rx_err_clr, .rx_rdata,
		.transfer_start_bit, .operating_flag, .shift_active_flag, .tx_buffer_empty_flag,
		.rx_buffer_full_flag, .tx_underrun_flag, .rx_overrun_flag, .port_irq, .sck_in, .sck_out,
		.sck_oe, .so_out, .si_in);
	ssfd_peer peer (.ext(ctrl_ext_clk), .lsb(ctrl_dir_lsb), .sck_out, .so_out, .tx_byte(peer_tx),
		.sck_in, .si_in, .rx_byte(peer_rx));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Interrupt pulses are one cycle wide, so count them here; also the hang limit
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (port_irq === 1'b1)
			irqs <= irqs + 1;
		if (cycles == 20000) begin
			miscompares++;
			conclude;
		end
	end
	task automatic conclude;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic chf(input logic got, input logic exp, input string m);
		chk({7'h0, got}, {7'h0, exp}, m);
	endtask
	// Stimulus driven through cyc changes 1 ns after a rising edge; peer.frame moves the pins in 62.5 ns steps
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic pls(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask
	task automatic ctl(input logic [1:0] md, input logic dir, ext, st, inh);
		{ctrl_mode, ctrl_dir_lsb, ctrl_ext_clk, ctrl_start, ctrl_inhibit} = {md, dir, ext, st, inh};
		pls(ctrl_wr);
	endtask
	task automatic wirq;
		k0 = irqs;
		for (int k = 0; k < 2000 && irqs == k0; k++)
			cyc(1);
		chk(8'(irqs - k0), 8'h1, "irq");
	endtask
	initial begin
		seed = 62807;
		{rst, ctrl_wr, ctrl_mode, ctrl_dir_lsb, ctrl_ext_clk, ctrl_start, ctrl_inhibit} = 8'h80;
		{tx_wr, tx_wdata, rx_rd, rx_err_clr, peer_tx} = 19'h0;
		{miscompares, check_count, irqs, cycles} = '0;
		repeat (5) @(posedge sys_clk);
		#1 rst = 1'b0;
		peer.clear;
		chf(tx_buffer_empty_flag & so_out & sck_out & ~operating_flag, 1'b1, "reset");
		tx_wdata = 8'($random(seed));
		pls(tx_wr);
		chf(tx_buffer_empty_flag, 1'b0, "tx write");
		ctl(2'h1, 1'b0, 1'b0, 1'b1, 1'b0);
		cyc(60);
		chf(operating_flag, 1'b0, "other mode idle");
		// Internal clock: random bytes, both bit orders, wait released by a tx write for every byte after the first
		for (i = 0; i < 6; i++) begin
			peer_tx = 8'($random(seed));
			ctl(SSFD_MODE_FULL_DUPLEX, i[0], 1'b0, 1'b1, 1'b0);
			if (i > 0) begin
				tx_wdata = 8'($random(seed));
				pls(tx_wr);
				cyc(2 * HALF + 2);
				chf(shift_active_flag, 1'b1, "resume");
			end
			wirq;
			cyc(HALF * 4);
			chk(rx_rdata, peer_tx, "rx byte");
			chk(peer_rx, tx_wdata, "tx byte");
			chf(rx_buffer_full_flag & tx_buffer_empty_flag & operating_flag, 1'b1, "flags");
			cyc(HALF * 6);
			chf(sck_out & sck_oe & ~shift_active_flag, 1'b1, "parked");
			pls(rx_rd);
			chf(rx_buffer_full_flag, 1'b0, "read clears");
		end
		ctl(SSFD_MODE_FULL_DUPLEX, 1'b0, 1'b0, 1'b0, 1'b0);
		cyc(20);
		chf(~operating_flag & so_out, 1'b1, "stopped");
		// External clock: underrun then overrun
		ctl(SSFD_MODE_FULL_DUPLEX, 1'b1, 1'b1, 1'b0, 1'b1);
		chf(tx_buffer_empty_flag & ~transfer_start_bit, 1'b1, "inhibit");
		ctl(SSFD_MODE_FULL_DUPLEX, 1'b1, 1'b1, 1'b1, 1'b0);
		peer.clear;
		// Serviced external byte: buffer written before and read after the frame
		tx_wdata = 8'($random(seed));
		pls(tx_wr);
		peer_tx = 8'($random(seed));
		peer.frame;
		cyc(8);
		chk(rx_rdata, peer_tx, "ext rx byte");
		chk(peer_rx, tx_wdata, "ext tx byte");
		chf(operating_flag & ~sck_oe & ~tx_underrun_flag, 1'b1, "ext flags");
		pls(rx_rd);
		b0 = 8'($random(seed));
		b1 = 8'($random(seed));
		for (i = 0; i < 2; i++) begin
			peer_tx = i ? b1 : b0;
			k0 = irqs;
			peer.frame;
			cyc(8);
			chk(8'(irqs - k0), {7'h0, ~i[0]}, "irq count");
			chk(rx_rdata, b0, "held byte");
			chk(peer_rx, 8'hff, "so high");
		end
		chf(tx_underrun_flag & rx_overrun_flag, 1'b1, "errors");
		ctl(SSFD_MODE_FULL_DUPLEX, 1'b1, 1'b1, 1'b0, 1'b0);
		pls(rx_rd);
		chk(rx_rdata, b1, "shift view");
		k0 = irqs;
		peer.frame;
		cyc(8);
		chf(~operating_flag & (irqs == k0), 1'b1, "stop no irq");
		pls(rx_err_clr);
		chf(rx_overrun_flag | rx_buffer_full_flag, 1'b0, "err clear");
		ctl(SSFD_MODE_FULL_DUPLEX, 1'b1, 1'b1, 1'b0, 1'b1);
		chf(~tx_underrun_flag & tx_buffer_empty_flag, 1'b1, "inhibit");
		conclude;
	end
endmodule // sync_serial_full_duplex_tb
`default_nettype wire
